/* File: verilog/wdg_regs.vh */
// register offsets, field positions, reset values and timing counts of the watchdog
// assumes a 32-bit axi4-lite slave port with byte addresses in the low eight bits
`ifndef WDG_REGS_VH
`define WDG_REGS_VH

`define WDG_OFF_MODE 8'h00
`define WDG_OFF_CLKSEL 8'h04
`define WDG_OFF_TIMEOUT 8'h08
`define WDG_OFF_FEED 8'h0C
`define WDG_OFF_COUNT 8'h10
`define WDG_OFF_WARN 8'h14
`define WDG_OFF_WINDOW 8'h18
`define WDG_OFF_STATUS 8'h1C

// mode register fields
`define WDG_MODE_EN 0
`define WDG_MODE_RESET_EN 1
`define WDG_MODE_WINDOWED 2
`define WDG_MODE_WARN_EN 3

// status register fields, write one to clear
`define WDG_ST_TIMEOUT 0
`define WDG_ST_FEED_ERR 1
`define WDG_ST_WARN 2
`define WDG_ST_WDRESET 3

// counting clock selection codes
`define WDG_SEL_IRC 2'h0
`define WDG_SEL_RING 2'h1
`define WDG_SEL_MAIN 2'h2

`define WDG_TIMEOUT_MIN 24'h0000_FF
`define WDG_TIMEOUT_RST 24'h0000_FF
`define WDG_WARN_RST 24'h0000_00
`define WDG_WINDOW_RST 24'hFFFF_FF

// fixed prescaler: four counting-clock periods per count
`define WDG_PRESCALE_LAST 2'h3

// feed sequence bytes
`define WDG_FEED_FIRST 8'hAA
`define WDG_FEED_SECOND 8'h55

`define WDG_RESP_OKAY 2'h0
`define WDG_RESP_SLVERR 2'h2

`endif

/* File: verilog/wdg_edge_sync.v */
// three-stage synchroniser for a free-running oscillator input, with rising-edge pulse
// assumes each oscillator level lasts at least two aclk cycles
`timescale 1ns/10ps
module wdg_edge_sync (
    input wire aclk,
    input wire aresetn,
    input wire osc_in,
    output wire rise_pulse
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    reg level_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= osc_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // accepted only once stages two and three agree; a one-cycle glitch is dropped
            if (s2_reg == s3_reg)
                level_reg <= s3_reg;
        end
    end

    // s1 feeds only s2; one pulse per accepted rising level
    assign rise_pulse = s2_reg & s3_reg & ~level_reg;
endmodule // wdg_edge_sync

/* File: verilog/wdg_feed_check.v */
// feed sequence checker: first byte then second byte, with no other write between
// assumes one-cycle write strobes from the register slave
`timescale 1ns/10ps
`include "wdg_regs.vh"
module wdg_feed_check (
    input wire aclk,
    input wire aresetn,
    input wire feed_wr,
    input wire [7:0] feed_data,
    input wire other_wr,
    output reg feed_ok,
    output reg feed_bad
);
    localparam ST_IDLE = 1'b0;
    localparam ST_ARMED = 1'b1;
    reg state_reg;
    reg state_next;

    always @*
    begin
        state_next = state_reg;
        feed_ok = 1'b0;
        feed_bad = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (feed_wr && feed_data == `WDG_FEED_FIRST)
                    state_next = ST_ARMED;
                else if (feed_wr)
                    feed_bad = 1'b1;
            end
            default:
            begin
                if (feed_wr && feed_data == `WDG_FEED_SECOND)
                begin
                    feed_ok = 1'b1;
                    state_next = ST_IDLE;
                end
                else if (feed_wr || other_wr)
                begin
                    // broken or interrupted sequence
                    feed_bad = 1'b1;
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end
endmodule // wdg_feed_check

/* File: verilog/wdg_watchdog.v */
// watchdog with optional reload window and early warning, axi4-lite register slave
// assumes oscillator pins are asynchronous, each level lasting two aclk cycles or more, and that
// chip_reset_req is wired to the chip reset network which in turn drives aresetn
//
// What this block does
// - once enabled and fed, expiry without reload requests a chip-wide reset, or an interrupt when reset enable is clear
// - enable is set by software; cleared only by reset, or by software after a watchdog event
// - wrong or incomplete feed sequence triggers the enabled reset or interrupt
// - sticky flag tells software the last reset came from the watchdog
// - 24-bit down-counter advanced by fixed prescaler from selected counting clock
// - time-out from 256x4 up to 2^24x4 counting periods, in steps of four
// - counting clock selectable among rc oscillator, ring oscillator, main clock
// - windowed mode accepts a reload only between programmed minimum and maximum
// - windowed mode may raise a warning interrupt at a programmed count
// - windowed mode limits counting clock to rc or ring oscillator
`timescale 1ns/10ps
`include "wdg_regs.vh"
module wdg_watchdog (
    input wire aclk,
    input wire aresetn,
    input wire power_on_resetn,
    input wire internal_rc_osc,
    input wire watchdog_ring_osc,
    input wire main_clock,
    input wire debug_halt,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg chip_reset_req,
    output wire watchdog_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // counting clock sources

    wire [2:0] osc_in;
    wire [2:0] osc_rise;
    assign osc_in = {main_clock, watchdog_ring_osc, internal_rc_osc};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_osc
            wdg_edge_sync u_sync (
                .aclk(aclk),
                .aresetn(aresetn),
                .osc_in(osc_in[gi]),
                .rise_pulse(osc_rise[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    reg enable_reg, reset_en_reg, windowed_reg, warn_en_reg, running_reg;
    reg to_flag_reg, err_flag_reg, warn_flag_reg, wdreset_flag_reg;
    reg [1:0] clksel_reg, presc_reg;
    reg [23:0] timeout_reg, warn_reg, window_reg, count_reg;

    // merges a write into an older word lane by lane
    function [31:0] merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer k;
        begin
            merge = old_val;
            for (k = 0; k < 4; k = k + 1)
                if (strb[k])
                    merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data are taken together

    wire wr_go;
    wire [31:0] wmode, wclk, wtime, wwarn, wwin, wstat;
    reg wr_mode, wr_clksel, wr_timeout, wr_feed, wr_warn, wr_window, wr_status, wr_hit;

    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;

    assign wmode = merge({28'h000_0000, warn_en_reg, windowed_reg, reset_en_reg, enable_reg},
                         s_axi_wdata, s_axi_wstrb);
    assign wclk = merge({30'h0000_0000, clksel_reg}, s_axi_wdata, s_axi_wstrb);
    assign wtime = merge({8'h00, timeout_reg}, s_axi_wdata, s_axi_wstrb);
    assign wwarn = merge({8'h00, warn_reg}, s_axi_wdata, s_axi_wstrb);
    assign wwin = merge({8'h00, window_reg}, s_axi_wdata, s_axi_wstrb);
    assign wstat = s_axi_wdata & {{28{1'b0}}, {4{s_axi_wstrb[0]}}};

    always @*
    begin
        wr_mode = 1'b0;
        wr_clksel = 1'b0;
        wr_timeout = 1'b0;
        wr_feed = 1'b0;
        wr_warn = 1'b0;
        wr_window = 1'b0;
        wr_status = 1'b0;
        wr_hit = 1'b1;
        if (s_axi_awaddr == `WDG_OFF_MODE)
            wr_mode = wr_go;
        else if (s_axi_awaddr == `WDG_OFF_CLKSEL)
            wr_clksel = wr_go;
        else if (s_axi_awaddr == `WDG_OFF_TIMEOUT)
            wr_timeout = wr_go;
        else if (s_axi_awaddr == `WDG_OFF_FEED)
            wr_feed = wr_go & s_axi_wstrb[0];
        else if (s_axi_awaddr == `WDG_OFF_WARN)
            wr_warn = wr_go;
        else if (s_axi_awaddr == `WDG_OFF_WINDOW)
            wr_window = wr_go;
        else if (s_axi_awaddr == `WDG_OFF_STATUS)
            wr_status = wr_go;
        else if (s_axi_awaddr != `WDG_OFF_COUNT)
            wr_hit = 1'b0;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WDG_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // feed sequence

    wire feed_ok;
    wire feed_bad;
    wire other_wr;
    assign other_wr = wr_go & ~wr_feed;

    wdg_feed_check u_feed (
        .aclk(aclk),
        .aresetn(aresetn),
        .feed_wr(wr_feed),
        .feed_data(s_axi_wdata[7:0]),
        .other_wr(other_wr),
        .feed_ok(feed_ok),
        .feed_bad(feed_bad)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // countdown

    reg sel_tick;
    wire count_tick, expire, early_feed, good_feed, bad_event, wd_event, warn_hit;

    always @*
    begin
        case (clksel_reg)
            `WDG_SEL_RING: sel_tick = osc_rise[1];
            `WDG_SEL_MAIN: sel_tick = windowed_reg ? osc_rise[1] : osc_rise[2];
            default: sel_tick = osc_rise[0];
        endcase
    end

    // one count every four counting-clock rising edges
    assign count_tick = sel_tick & (presc_reg == `WDG_PRESCALE_LAST)
                        & running_reg & enable_reg & ~debug_halt;
    assign expire = count_tick & (count_reg == 24'h0000_00);
    // reload before the minimum elapsed time is a window violation
    assign early_feed = windowed_reg & (count_reg > window_reg);
    assign good_feed = feed_ok & ~early_feed;
    assign bad_event = enable_reg & (feed_bad | (feed_ok & early_feed));
    assign wd_event = expire | bad_event;
    assign warn_hit = count_tick & windowed_reg & warn_en_reg & (count_reg == warn_reg);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            presc_reg <= 2'h0;
            count_reg <= `WDG_TIMEOUT_RST;
            running_reg <= 1'b0;
        end
        else
        begin
            if (sel_tick && !debug_halt)
                presc_reg <= presc_reg + 2'h1;
            if (good_feed)
            begin
                // the load and the synchronised ticks are both in the aclk domain, so no crossing hazard here
                count_reg <= timeout_reg;
                presc_reg <= 2'h0;
                running_reg <= 1'b1;
            end
            else if (wd_event)
                running_reg <= 1'b0;
            else if (count_tick)
                count_reg <= count_reg - 24'h0000_01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    wire event_flag;
    assign event_flag = to_flag_reg | err_flag_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_reg <= 1'b0;
            reset_en_reg <= 1'b0;
            windowed_reg <= 1'b0;
            warn_en_reg <= 1'b0;
            clksel_reg <= `WDG_SEL_IRC;
            timeout_reg <= `WDG_TIMEOUT_RST;
            warn_reg <= `WDG_WARN_RST;
            window_reg <= `WDG_WINDOW_RST;
        end
        else
        begin
            if (wr_mode)
            begin
                // software may only clear enable after a watchdog interrupt event
                if (wmode[`WDG_MODE_EN] || event_flag)
                    enable_reg <= wmode[`WDG_MODE_EN];
                reset_en_reg <= wmode[`WDG_MODE_RESET_EN];
                windowed_reg <= wmode[`WDG_MODE_WINDOWED];
                warn_en_reg <= wmode[`WDG_MODE_WARN_EN];
            end
            if (wr_clksel)
                clksel_reg <= wclk[1:0];
            if (wr_timeout)
            begin
                if (wtime[23:0] < `WDG_TIMEOUT_MIN)
                    timeout_reg <= `WDG_TIMEOUT_MIN;
                else
                    timeout_reg <= wtime[23:0];
            end
            if (wr_warn)
                warn_reg <= wwarn[23:0];
            if (wr_window)
                window_reg <= wwin[23:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event flags and consequences; a set in the clearing cycle wins

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            to_flag_reg <= 1'b0;
            err_flag_reg <= 1'b0;
            warn_flag_reg <= 1'b0;
            chip_reset_req <= 1'b0;
        end
        else
        begin
            chip_reset_req <= wd_event & reset_en_reg;
            if (expire)
                to_flag_reg <= 1'b1;
            else if (wr_status && wstat[`WDG_ST_TIMEOUT])
                to_flag_reg <= 1'b0;
            if (bad_event)
                err_flag_reg <= 1'b1;
            else if (wr_status && wstat[`WDG_ST_FEED_ERR])
                err_flag_reg <= 1'b0;
            if (warn_hit)
                warn_flag_reg <= 1'b1;
            else if (wr_status && wstat[`WDG_ST_WARN])
                warn_flag_reg <= 1'b0;
        end
    end

    // survives the chip reset that the watchdog itself causes
    always @(posedge aclk)
    begin
        if (!power_on_resetn)
            wdreset_flag_reg <= 1'b0;
        else if (wd_event && reset_en_reg)
            wdreset_flag_reg <= 1'b1;
        else if (wr_status && wstat[`WDG_ST_WDRESET])
            wdreset_flag_reg <= 1'b0;
    end

    assign watchdog_irq = (event_flag & ~reset_en_reg) | warn_flag_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    reg [31:0] rd_word;
    reg rd_hit;
    wire rd_go;
    assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (s_axi_araddr == `WDG_OFF_MODE)
            rd_word = {28'h000_0000, warn_en_reg, windowed_reg, reset_en_reg, enable_reg};
        else if (s_axi_araddr == `WDG_OFF_CLKSEL)
            rd_word = {30'h0000_0000, clksel_reg};
        else if (s_axi_araddr == `WDG_OFF_TIMEOUT)
            rd_word = {8'h00, timeout_reg};
        else if (s_axi_araddr == `WDG_OFF_COUNT)
            rd_word = {8'h00, count_reg};
        else if (s_axi_araddr == `WDG_OFF_WARN)
            rd_word = {8'h00, warn_reg};
        else if (s_axi_araddr == `WDG_OFF_WINDOW)
            rd_word = {8'h00, window_reg};
        else if (s_axi_araddr == `WDG_OFF_STATUS)
            rd_word = {28'h000_0000, wdreset_flag_reg, warn_flag_reg, err_flag_reg,
                       to_flag_reg};
        else if (s_axi_araddr != `WDG_OFF_FEED)
            rd_hit = 1'b0;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `WDG_RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // wdg_watchdog

/* File: testbench/wdg_chip_side.sv */
// far-side model: the chip reset tree driven by the watchdog reset request
// assumes bench_resetn is the board reset, synchronous to aclk
`timescale 1ns/10ps
module wdg_chip_side (
    input wire aclk,
    input wire bench_resetn,
    input wire chip_reset_req,
    output reg aresetn,
    output reg [31:0] resets
);
    integer hold = 0;
    initial
    begin
        aresetn = 1'b0;
        resets = 32'h0000_0000;
    end
    // a request holds the chip in reset for several cycles, like a real tree
    always @(posedge aclk)
    begin
        if (chip_reset_req)
        begin
            hold <= 4;
            resets <= resets + 32'h0000_0001;
        end
        else if (hold > 0)
            hold <= hold - 1;
        aresetn <= bench_resetn && !chip_reset_req && hold <= 1;
    end
endmodule // wdg_chip_side

/* File: testbench/wdg_watchdog_chk.sv */
// concurrent checks on the watchdog bus slave, reset request and interrupt
// assumes it is bound to wdg_watchdog and sees only its ports
`timescale 1ns/10ps
module wdg_watchdog_chk (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire chip_reset_req,
    input wire watchdog_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    sequence wr_taken;
        wr_go;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && !s_axi_rvalid;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_write_answer: assert property (wr_taken |-> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
        else $error("write not answered one cycle after it was taken");
    chk_write_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before bready");
    chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("new write accepted while a response is pending");
    chk_read_answer: assert property (rd_taken |-> s_axi_arready ##1 s_axi_rvalid)
        else $error("read not answered one cycle after it was taken");
    chk_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before rready");
    chk_read_unmapped: assert property (rd_taken ##0 s_axi_araddr > 8'h1c |=> s_axi_rresp == 2'h2)
        else $error("unmapped read not answered with slave error");
    chk_reset_pulse: assert property ($rose(chip_reset_req) |=> !chip_reset_req)
        else $error("chip reset request longer than one cycle");
    chk_irq_sticky: assert property (watchdog_irq && !wr_go |=> watchdog_irq)
        else $error("interrupt dropped without a register write");
endmodule // wdg_watchdog_chk
bind wdg_watchdog wdg_watchdog_chk chk_u (.*);

/* File: testbench/tb_wdg_watchdog.sv */
// self-checking bench: axi4-lite master, three oscillators, reset tree model
// assumes every bus request is answered within a hundred cycles
`timescale 1ns/10ps
module tb_wdg_watchdog;
    reg aclk, bench_resetn, power_on_resetn, ph;
    reg internal_rc_osc, watchdog_ring_osc, main_clock;
    reg [2:0] osc_on;
    reg [7:0] awaddr, araddr;
    reg [31:0] wdata, d, seed;
    reg awvalid, wvalid, bready, arvalid, rready;
    reg [1:0] r;
    reg [31:0] model [0:7];
    wire aresetn, awready, wready, bvalid, arready, rvalid, chip_reset_req, watchdog_irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, resets;
    integer mismatches, compares, i, n;
    wdg_watchdog dut_u (
        .aclk(aclk), .aresetn(aresetn), .power_on_resetn(power_on_resetn),
        .internal_rc_osc(internal_rc_osc), .watchdog_ring_osc(watchdog_ring_osc),
        .main_clock(main_clock), .debug_halt(1'b0),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chip_reset_req(chip_reset_req), .watchdog_irq(watchdog_irq)
    );
    wdg_chip_side side_u (.aclk(aclk), .bench_resetn(bench_resetn),
        .chip_reset_req(chip_reset_req), .aresetn(aresetn), .resets(resets));
    always #5 aclk = ~aclk;
    // each running oscillator toggles every other cycle, well below aclk/2
    always @(posedge aclk)
    begin
        ph <= !ph;
        if (ph)
            {main_clock, watchdog_ring_osc, internal_rc_osc} <=
                {main_clock, watchdog_ring_osc, internal_rc_osc} ^ osc_on;
    end
    ////////////////////////////////////////////////////////////////////////
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    function sig(input [2:0] s);
        case (s)
            0: sig = watchdog_irq;
            1: sig = chip_reset_req;
            2: sig = awready & wready;
            3: sig = bvalid;
            4: sig = arready;
            default: sig = rvalid;
        endcase
    endfunction
    task conclude;
        begin
            if (mismatches == 0 && compares > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] s);
        begin
            compares = compares + 1;
            if (s !== e)
            begin
                mismatches = mismatches + 1;
                $display("[ERR] %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    // looks at the settled level mid-cycle, returns on the edge that takes it
    task wait_hi(input [2:0] s, input integer lim);
        begin
            n = 0;
            @(negedge aclk);
            while (sig(s) !== 1'b1 && n < lim)
            begin
                @(negedge aclk);
                n = n + 1;
            end
            if (n >= lim)
            begin
                mismatches = mismatches + 1;
                conclude;
            end
            d = rdata;
            r = (s == 3'h3) ? bresp : rresp;
            @(posedge aclk);
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            wait_hi(2, 100);
            awvalid <= 1'b0;
            wvalid <= 1'b0;
            bready <= 1'b1;
            wait_hi(3, 100);
            bready <= 1'b0;
            if (a == 8'h08)
                model[2] = (v[23:0] < 24'h00_00ff) ? 32'h0000_00ff : {8'h00, v[23:0]};
            else if (a == 8'h14 || a == 8'h18)
                model[a[4:2]] = {8'h00, v[23:0]};
        end
    endtask
    task rd(input [7:0] a);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            wait_hi(4, 100);
            arvalid <= 1'b0;
            rready <= 1'b1;
            wait_hi(5, 100);
            rready <= 1'b0;
        end
    endtask
    task feed;
        begin
            wr(8'h0c, 32'h0000_00aa);
            wr(8'h0c, 32'h0000_0055);
        end
    endtask
    task model_init;
        begin
            for (i = 0; i < 8; i = i + 1)
                model[i] = 32'h0000_0000;
            model[2] = 32'h0000_00ff;
            model[4] = 32'h0000_00ff;
            model[6] = 32'h00ff_ffff;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        {bench_resetn, power_on_resetn, ph} = 3'h0;
        {internal_rc_osc, watchdog_ring_osc, main_clock} = 3'h0;
        osc_on = 3'h1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        mismatches = 0;
        compares = 0;
        seed = 32'h0000_004c;
        model_init;
        repeat (12) @(posedge aclk);
        bench_resetn <= 1'b1;
        power_on_resetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 8; i = i + 1)
        begin
            rd({i[5:0], 2'b00});
            chk("reset_value", model[i], d);
        end
        rd(8'h20);
        chk("unmapped_resp", 32'h2, r);
        wr(8'h20, 32'h0000_0000);
        chk("unmapped_wr_resp", 32'h2, r);
        wr(8'h08, 32'h0000_0010);
        chk("write_resp", 32'h0, r);
        rd(8'h08);
        chk("timeout_min", model[2], d);
        seed = xs(seed);
        wr(8'h14, seed);
        rd(8'h14);
        chk("warn_value", model[5], d);
        // interrupt mode first, so a slip here cannot reset the bench
        wr(8'h00, 32'h0000_0001);
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(8'h04, i);
            osc_on <= 3'h1 << i;
            feed;
            repeat (200) @(posedge aclk);
            rd(8'h10);
            chk("count_rate", 1, d >= 32'hf0 && d <= 32'hf4);
        end
        wr(8'h00, 32'h0000_0000);
        rd(8'h00);
        chk("enable_kept", 32'h1, d & 32'h1);
        for (i = 0; i < 2; i = i + 1)
        begin
            feed;
            if (i == 0)
                wr(8'h0c, 32'h0000_0055);
            else
            begin
                wr(8'h0c, 32'h0000_00aa);
                wr(8'h18, model[6]);
            end
            wait_hi(0, 20);
            rd(8'h1c);
            chk("feed_error", 32'h2, d & 32'hf);
            chk("no_chip_reset", 0, resets);
            if (i == 1)
            begin
                wr(8'h00, 32'h0000_0000);
                rd(8'h00);
                chk("enable_cleared", 32'h0, d & 32'h1);
            end
            wr(8'h1c, 32'h0000_000f);
            chk("irq_cleared", 32'h0, watchdog_irq);
        end
        wr(8'h00, 32'h0000_0003);
        wr(8'h04, 32'h0000_0000);
        osc_on <= 3'h1;
        feed;
        repeat (400) @(posedge aclk);
        rd(8'h10);
        chk("count_runs", 1, d < 32'hff);
        feed;
        rd(8'h10);
        chk("count_reload", 1, d >= 32'hfe);
        wait_hi(1, 5000);
        chk("timeout_period", 1, n >= 4070 && n <= 4110);
        repeat (10) @(posedge aclk);
        model_init;
        rd(8'h1c);
        chk("wd_reset_flag", 32'h8, d & 32'h8);
        rd(8'h00);
        chk("mode_after_reset", model[0], d);
        // windowed: main clock code must fall back to the ring oscillator
        wr(8'h14, 32'h0000_00f0);
        wr(8'h04, 32'h0000_0002);
        osc_on <= 3'h2;
        wr(8'h00, 32'h0000_000d);
        feed;
        wr(8'h18, 32'h0000_0080);
        wait_hi(0, 400);
        chk("warn_time", 1, n >= 190 && n <= 270);
        rd(8'h1c);
        chk("warn_flag", 32'h4, d & 32'h7);
        feed;
        rd(8'h1c);
        chk("window_refused", 32'h6, d & 32'h7);
        conclude;
    end
endmodule // tb_wdg_watchdog
